/* File: logic/rx_decoder_cfg.svh */
`ifndef RX_DECODER_CFG_SVH
`define RX_DECODER_CFG_SVH
// register indices; byte address is four times the index
`define IDX_RX_CTL_ONE      6'h19
`define IDX_DECODER_SETUP   6'h1A
`define IDX_TX_RX_PHASE     6'h1B
`define IDX_THRESHOLDS      6'h1C
`define IDX_PSK_DEMOD       6'h1D
`define IDX_IRQ_STATUS      6'h20
`define IDX_IRQ_MASK        6'h21
`define IDX_DECODER_STATE   6'h22
// reset values
`define RST_RX_CTL_ONE      8'h73
`define RST_DECODER_SETUP   8'h08
`define RST_TX_RX_PHASE     8'hAD
`define RST_THRESHOLDS      8'hFF
`define RST_PSK_DEMOD       8'h1E
`define RST_IRQ             4'h0
// field positions
`define F_PULSES_HI         7
`define F_PULSES_LO         5
`define F_PROTO_HI          4
`define F_PROTO_LO          3
`define F_LP_OFF            2
`define F_GAIN_HI           1
`define F_GAIN_LO           0
`define F_MULTI             6
`define F_MASK_COLL         5
`define F_FRAMING_HI        4
`define F_FRAMING_LO        3
`define F_LINE_CODE         0
`define F_MIN_HI            7
`define F_MIN_LO            4
`define F_COLL_HI           3
`define F_COLL_LO           0
`define F_IGN_START         7
`define F_IGN_GUARD         6
`define F_IGN_END           5
`define F_FILTER_AMP        4
`define F_TAU_RX_HI         3
`define F_TAU_RX_LO         2
`define F_TAU_BURST_HI      1
`define F_TAU_BURST_LO      0
// interrupt status bits
`define IRQ_FRAME_DONE      0
`define IRQ_COLLISION       1
`define IRQ_FRAMING         2
`define IRQ_CONFIG          3
// codes
`define PROTO_TYPE_AB       2'h2
`define FRAMING_TYPE_A      2'h1
`endif

/* File: logic/rx_decoder_pkg.sv */
package rx_decoder_pkg;
  typedef enum logic [1:0] {
    RX_OFF  = 2'h0,
    RX_ON   = 2'h1,
    RX_HOLD = 2'h3
  } rx_state_t;
  typedef logic [7:0] reg8_t;
endpackage

/* File: logic/rx_decoder_regs.sv */
// Notes on behaviour
// RL1: codes 000..011 give 1, 2, 4 or 8 pulses per bit; 101..111 reserved.
// RL2: protocol code 10 selects Type A and B; codes 00 and 11 are reserved.
// RL3: gain codes 00..11 give 20, 24, 31 and 35 dB.
// RL4: multi-frame clear stops the receiver after one frame, set keeps it on.
// RL5: with masking set, bits after a detected collision are stored as zero.
// RL6: framing code 01 makes the decoder expect Type A framing.
// RL7: software keeps the reserved decoder setup bits 7 and 2..1 as they are.
// RL8: an eight-bit value sets the tx to rx clock phase, reset value ADh.
// RL9: input weaker than the four-bit minimum level is not evaluated.
// RL10: collision needs weak half-bit at collision level relative to strong.
// RL11: missing start of frame is a framing error unless bit 7 is set.
// RL12: a bad extra guard time is a framing error unless bit 6 is set.
// RL13: missing end of frame is a framing error unless bit 5 is set.
// RL14: one PLL time constant applies while receiving, another during bursts.
// RL15: line code 0 selects Manchester, 1 selects phase-shift decoding.
// RL16: all registers read and write and load their defaults on reset; status bits clear on writing ones, decoder state is read only.
`include "rx_decoder_cfg.svh"
`timescale 1ns/100ps
`default_nettype none
module rx_decoder_regs #(
  parameter int AMP_W = 4
) (
  input  wire logic             clk,
  input  wire logic             rst,
  input  wire logic             hsel,
  input  wire logic [7:0]       haddr,
  input  wire logic [1:0]       htrans,
  input  wire logic             hwrite,
  input  wire logic [2:0]       hsize,
  input  wire logic [31:0]      hwdata,
  input  wire logic             hready,
  output logic      [31:0]      hrdata,
  output logic                  hreadyout,
  output logic                  hresp,
  input  wire logic             rx_start,
  input  wire logic             frame_end,
  input  wire logic             burst_phase,
  input  wire logic             sym_valid,
  input  wire logic [AMP_W-1:0] sym_first_amp,
  input  wire logic [AMP_W-1:0] sym_second_amp,
  input  wire logic             psk_bit_valid,
  input  wire logic             psk_bit,
  input  wire logic [AMP_W-1:0] psk_strength,
  input  wire logic             missing_start,
  input  wire logic             guard_time_bad,
  input  wire logic             missing_end,
  output logic      [3:0]       pulses_per_bit,
  output logic      [1:0]       protocol_select,
  output logic      [5:0]       gain_db,
  output logic                  low_pass_off,
  output logic                  framing_type_a,
  output logic      [7:0]       tx_rx_phase_offset,
  output logic                  filter_amp_det,
  output logic      [1:0]       pll_time_constant,
  output logic                  receiver_on,
  output logic                  rx_bit,
  output logic                  rx_bit_valid,
  output logic                  bit_collision,
  output logic                  framing_error,
  output logic                  irq
);
  if (AMP_W < 4)
  begin : g_amp_w_check
    $error("AMP_W must be at least 4");
  end

  // ==========================================================
  // bus address phase
  // ==========================================================
  logic        xfer_take;
  logic [5:0]  xfer_idx;
  logic        wr_pend_r;
  logic [5:0]  wr_idx_r;

  assign xfer_take = hsel & htrans[1] & hready;
  assign xfer_idx  = haddr[7:2];

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      wr_pend_r <= 1'b0;
      wr_idx_r  <= 6'h00;
    end
    else
    begin
      wr_pend_r <= xfer_take & hwrite;
      wr_idx_r  <= xfer_idx;
    end
  end

  // ==========================================================
  // register write decode
  // ==========================================================
  rx_decoder_pkg::reg8_t rx_ctl_r;
  rx_decoder_pkg::reg8_t dec_setup_r;
  rx_decoder_pkg::reg8_t phase_r;
  rx_decoder_pkg::reg8_t thresh_r;
  rx_decoder_pkg::reg8_t psk_r;
  logic [3:0]  irq_stat_r;
  logic [3:0]  irq_mask_r;
  logic [7:0]  wdata;
  logic        wr_rx_ctl;
  logic        wr_dec_setup;
  logic        wr_phase;
  logic        wr_thresh;
  logic        wr_psk;
  logic        wr_stat;
  logic        wr_mask;

  assign wdata        = hwdata[7:0];
  assign wr_rx_ctl    = wr_pend_r & (wr_idx_r == `IDX_RX_CTL_ONE);
  assign wr_dec_setup = wr_pend_r & (wr_idx_r == `IDX_DECODER_SETUP);
  assign wr_phase     = wr_pend_r & (wr_idx_r == `IDX_TX_RX_PHASE);
  assign wr_thresh    = wr_pend_r & (wr_idx_r == `IDX_THRESHOLDS);
  assign wr_psk       = wr_pend_r & (wr_idx_r == `IDX_PSK_DEMOD);
  assign wr_stat      = wr_pend_r & (wr_idx_r == `IDX_IRQ_STATUS);
  assign wr_mask      = wr_pend_r & (wr_idx_r == `IDX_IRQ_MASK);

  // every bit stored as written, reserved ones included, except mask bits 7..4
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      rx_ctl_r    <= `RST_RX_CTL_ONE;    // RL16
      dec_setup_r <= `RST_DECODER_SETUP; // RL16
      phase_r     <= `RST_TX_RX_PHASE;   // RL8
      thresh_r    <= `RST_THRESHOLDS;    // RL16
      psk_r       <= `RST_PSK_DEMOD;     // RL16
      irq_mask_r  <= `RST_IRQ;
    end
    else
    begin
      if (wr_rx_ctl)
        rx_ctl_r <= wdata;
      if (wr_dec_setup)
        dec_setup_r <= wdata;            // RL7
      if (wr_phase)
        phase_r <= wdata;                // RL8
      if (wr_thresh)
        thresh_r <= wdata;
      if (wr_psk)
        psk_r <= wdata;
      if (wr_mask)
        irq_mask_r <= wdata[3:0];
    end
  end

  // ==========================================================
  // field views
  // ==========================================================
  logic [2:0] pulse_code;
  logic [1:0] proto_code;
  logic [1:0] gain_code;
  logic       multi_frame_receive;
  logic       mask_after_collision;
  logic [1:0] receive_framing_select;
  logic       receive_line_code;
  logic [3:0] min_signal_threshold;
  logic [3:0] collision_threshold;
  logic       ignore_missing_start;
  logic       ignore_guard_time_error;
  logic       ignore_missing_end;
  logic [1:0] pll_receive_time_constant;
  logic [1:0] pll_burst_time_constant;

  assign pulse_code   = rx_ctl_r[`F_PULSES_HI:`F_PULSES_LO];
  assign proto_code   = rx_ctl_r[`F_PROTO_HI:`F_PROTO_LO];
  assign gain_code    = rx_ctl_r[`F_GAIN_HI:`F_GAIN_LO];
  assign multi_frame_receive    = dec_setup_r[`F_MULTI];
  assign mask_after_collision   = dec_setup_r[`F_MASK_COLL];
  assign receive_framing_select =
    dec_setup_r[`F_FRAMING_HI:`F_FRAMING_LO];
  assign receive_line_code      = dec_setup_r[`F_LINE_CODE];
  assign min_signal_threshold   = thresh_r[`F_MIN_HI:`F_MIN_LO];
  assign collision_threshold    = thresh_r[`F_COLL_HI:`F_COLL_LO];
  assign ignore_missing_start    = psk_r[`F_IGN_START];
  assign ignore_guard_time_error = psk_r[`F_IGN_GUARD];
  assign ignore_missing_end      = psk_r[`F_IGN_END];
  assign pll_receive_time_constant =
    psk_r[`F_TAU_RX_HI:`F_TAU_RX_LO];
  assign pll_burst_time_constant   =
    psk_r[`F_TAU_BURST_HI:`F_TAU_BURST_LO];

  // ==========================================================
  // decoded settings
  // ==========================================================
  logic [3:0] pulses_nxt;
  logic [5:0] gain_nxt;
  logic       cfg_bad_wr;

  // reserved pulse codes keep the eight-pulse setting
  assign pulses_nxt = (pulse_code == 3'h0) ? 4'h1 :
                      (pulse_code == 3'h1) ? 4'h2 :
                      (pulse_code == 3'h2) ? 4'h4 : 4'h8;   // RL1
  assign gain_nxt   = (gain_code == 2'h0) ? 6'h14 :
                      (gain_code == 2'h1) ? 6'h18 :
                      (gain_code == 2'h2) ? 6'h1F : 6'h23;  // RL3
  // reserved pulse or protocol code written
  assign cfg_bad_wr = wr_rx_ctl &
    ((wdata[`F_PULSES_HI:`F_PULSES_LO] > 3'h4) |
     (wdata[`F_PROTO_HI:`F_PROTO_LO] == 2'h0) |
     (wdata[`F_PROTO_HI:`F_PROTO_LO] == 2'h3));             // RL1 RL2

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      pulses_per_bit    <= 4'h8;
      gain_db           <= 6'h23;
      pll_time_constant <= 2'h0;
      framing_type_a    <= 1'b0;
    end
    else
    begin
      pulses_per_bit    <= pulses_nxt;
      gain_db           <= gain_nxt;
      pll_time_constant <= burst_phase ? pll_burst_time_constant
                                       : pll_receive_time_constant; // RL14
      framing_type_a    <=
        (receive_framing_select == `FRAMING_TYPE_A);        // RL6
    end
  end

  assign protocol_select    = proto_code;                   // RL2
  assign low_pass_off       = rx_ctl_r[`F_LP_OFF];
  assign tx_rx_phase_offset = phase_r;                      // RL8
  assign filter_amp_det     = psk_r[`F_FILTER_AMP];
  // ==========================================================
  // receiver on and off
  // ==========================================================
  rx_decoder_pkg::rx_state_t rx_state_r;
  rx_decoder_pkg::rx_state_t rx_state_nxt;

  always_comb
  begin
    rx_state_nxt = rx_state_r;
    unique case (rx_state_r)
      rx_decoder_pkg::RX_OFF:
        if (rx_start)
          rx_state_nxt = rx_decoder_pkg::RX_ON;
      rx_decoder_pkg::RX_ON:
        if (frame_end && !multi_frame_receive)
          rx_state_nxt = rx_decoder_pkg::RX_HOLD;           // RL4
      rx_decoder_pkg::RX_HOLD:
        rx_state_nxt = rx_decoder_pkg::RX_OFF;
      default:
        rx_state_nxt = rx_decoder_pkg::RX_OFF;
    endcase
  end

  logic rx_live;
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      rx_state_r <= rx_decoder_pkg::RX_OFF;
      rx_live    <= 1'b0;
    end
    else
    begin
      rx_state_r <= rx_state_nxt;
      rx_live    <= (rx_state_nxt == rx_decoder_pkg::RX_ON);   // RL4
    end
  end
  assign receiver_on = rx_live;

  // ==========================================================
  // bit decision
  // ==========================================================
  logic [AMP_W-1:0] amp_strong;
  logic [AMP_W-1:0] amp_weak;
  logic [AMP_W-1:0] min_level;
  logic [AMP_W+3:0] weak_scaled;
  logic [AMP_W+3:0] coll_scaled;
  logic             man_ok;
  logic             man_coll;
  logic             psk_ok;
  logic             coll_seen_r;
  logic             bit_raw;
  logic             bit_ok;

  assign amp_strong  = (sym_first_amp >= sym_second_amp) ?
                       sym_first_amp : sym_second_amp;
  assign amp_weak    = (sym_first_amp >= sym_second_amp) ?
                       sym_second_amp : sym_first_amp;
  assign min_level   = AMP_W'(min_signal_threshold);
  // weak / strong >= level / 16
  assign weak_scaled = {amp_weak, 4'h0};
  assign coll_scaled = (AMP_W+4)'(amp_strong * collision_threshold);
  assign man_ok   = rx_live & sym_valid & !receive_line_code &
                    (amp_strong >= min_level);              // RL9 RL15
  assign man_coll = man_ok & (weak_scaled >= coll_scaled);  // RL10
  assign psk_ok   = rx_live & psk_bit_valid & receive_line_code &
                    (psk_strength >= min_level);            // RL9 RL15
  assign bit_raw  = receive_line_code ? psk_bit
                    : (sym_first_amp > sym_second_amp);     // RL15
  assign bit_ok   = man_ok | psk_ok;

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      rx_bit        <= 1'b0;
      rx_bit_valid  <= 1'b0;
      bit_collision <= 1'b0;
      coll_seen_r   <= 1'b0;
    end
    else
    begin
      rx_bit_valid  <= bit_ok;
      bit_collision <= man_coll;
      rx_bit        <= bit_ok & !man_coll & bit_raw &
                       !(mask_after_collision & coll_seen_r); // RL5
      if (rx_start | frame_end)
        coll_seen_r <= 1'b0;
      else if (man_coll)
        coll_seen_r <= 1'b1;                                // RL5
    end
  end

  // ==========================================================
  // framing errors
  // ==========================================================
  logic frame_err_ev;

  assign frame_err_ev = rx_live &
    ((missing_start  & !ignore_missing_start)  |            // RL11
     (guard_time_bad & !ignore_guard_time_error) |          // RL12
     (missing_end    & !ignore_missing_end));               // RL13

  always_ff @(posedge clk)
  begin
    if (rst)
      framing_error <= 1'b0;
    else
      framing_error <= frame_err_ev;
  end

  // ==========================================================
  // interrupt status, set wins over clear
  // ==========================================================
  logic [3:0] irq_ev;
  logic [3:0] irq_clr;

  assign irq_ev  = {cfg_bad_wr, frame_err_ev, man_coll,
                    rx_live & frame_end};
  assign irq_clr = wr_stat ? wdata[3:0] : 4'h0;

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      irq_stat_r <= `RST_IRQ;
      irq        <= 1'b0;
    end
    else
    begin
      irq_stat_r <= (irq_stat_r & ~irq_clr) | irq_ev;
      irq        <= |(((irq_stat_r & ~irq_clr) | irq_ev) & irq_mask_r);
    end
  end

  // ==========================================================
  // read data
  // ==========================================================
  logic [7:0] rd_sel;

  assign rd_sel =
    (xfer_idx == `IDX_RX_CTL_ONE)    ? rx_ctl_r    :
    (xfer_idx == `IDX_DECODER_SETUP) ? dec_setup_r :
    (xfer_idx == `IDX_TX_RX_PHASE)   ? phase_r     :
    (xfer_idx == `IDX_THRESHOLDS)    ? thresh_r    :
    (xfer_idx == `IDX_PSK_DEMOD)     ? psk_r       :
    (xfer_idx == `IDX_IRQ_STATUS)    ? {4'h0, irq_stat_r} :
    (xfer_idx == `IDX_IRQ_MASK)      ? {4'h0, irq_mask_r} :
    (xfer_idx == `IDX_DECODER_STATE) ?
      {5'h00, coll_seen_r, rx_state_r} : 8'h00;

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      hrdata    <= 32'h0000_0000;
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end
    else
    begin
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
      if (xfer_take & !hwrite)
        hrdata <= {24'h00_0000, rd_sel};
    end
  end
  logic unused_ok;
  assign unused_ok = &{1'b0, hsize, hwdata[31:8]};
endmodule // rx_decoder_regs
`default_nettype wire

/* File: test/rx_decoder_sva.sv */
`timescale 1ns/100ps
`default_nettype none
module rx_decoder_sva (
  input wire logic       clk,
  input wire logic       rst,
  input wire logic       hreadyout,
  input wire logic       hresp,
  input wire logic [5:0] gain_db,
  input wire logic [3:0] pulses_per_bit,
  input wire logic       receiver_on,
  input wire logic       rx_start,
  input wire logic       frame_end,
  input wire logic       sym_valid,
  input wire logic       psk_bit_valid,
  input wire logic       rx_bit,
  input wire logic       rx_bit_valid,
  input wire logic       bit_collision,
  input wire logic       framing_error,
  input wire logic       missing_start,
  input wire logic       guard_time_bad,
  input wire logic       missing_end
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  // ====================================================
  // bus and receive path checks
  chk_bus_okay: assert property (hreadyout && !hresp)
    else $error("bus answer not zero-wait okay");
  chk_gain_steps: assert property (
    gain_db inside {6'h14, 6'h18, 6'h1F, 6'h23})
    else $error("gain outside its four steps");
  chk_pulse_steps: assert property (
    pulses_per_bit inside {4'h1, 4'h2, 4'h4, 4'h8})
    else $error("pulse count outside 1 2 4 8");
  chk_bit_cause: assert property (
    rx_bit_valid |-> $past(receiver_on && (sym_valid || psk_bit_valid)))
    else $error("bit without accepted input");
  chk_coll_cause: assert property (
    bit_collision |-> !rx_bit && $past(receiver_on && sym_valid))
    else $error("collision without symbol or nonzero");
  chk_stay_on: assert property (
    receiver_on && !frame_end |=> receiver_on)
    else $error("receiver dropped without frame end");
  chk_stop_cause: assert property (
    $fell(receiver_on) && !$past(rst) |-> $past(frame_end))
    else $error("receiver off without frame end");
  chk_hold_cycle: assert property (
    $fell(receiver_on) |=> !receiver_on)
    else $error("receiver restarted during hold");
  chk_start_on: assert property (
    rx_start && !receiver_on && !$past(receiver_on) |=> receiver_on)
    else $error("start did not switch receiver on");
  chk_err_cause: assert property (
    framing_error |-> $past(receiver_on &&
      (missing_start || guard_time_bad || missing_end)))
    else $error("framing error without fault");
endmodule // rx_decoder_sva

bind rx_decoder_regs rx_decoder_sva i_rx_decoder_sva (
  .clk, .rst, .hreadyout, .hresp, .gain_db, .pulses_per_bit,
  .receiver_on, .rx_start, .frame_end, .sym_valid, .psk_bit_valid,
  .rx_bit, .rx_bit_valid, .bit_collision, .framing_error,
  .missing_start, .guard_time_bad, .missing_end
);
`default_nettype wire

/* File: test/card_model.sv */
`timescale 1ns/100ps
`default_nettype none
module card_model #(
  parameter int AMP_W = 4
) (
  input  wire logic             clk,
  output logic                  rx_start,
  output logic                  frame_end,
  output logic                  burst_phase,
  output logic                  sym_valid,
  output logic      [AMP_W-1:0] sym_first_amp,
  output logic      [AMP_W-1:0] sym_second_amp,
  output logic                  psk_bit_valid,
  output logic                  psk_bit,
  output logic      [AMP_W-1:0] psk_strength,
  output logic                  missing_start,
  output logic                  guard_time_bad,
  output logic                  missing_end
);
  initial
  begin
    {rx_start, frame_end, burst_phase, sym_valid, psk_bit_valid} = 5'h00;
    {psk_bit, missing_start, guard_time_bad, missing_end} = 4'h0;
    sym_first_amp = {AMP_W{1'b0}};
    sym_second_amp = {AMP_W{1'b0}};
    psk_strength = {AMP_W{1'b0}};
  end
  // ====================================================
  // events: 0 start, 1 end, 2 no start, 3 guard, 4 no end
  task ev(input int k);
    @(posedge clk);
    {rx_start, frame_end, missing_start, guard_time_bad, missing_end}
      <= 5'h10 >> k;
    @(posedge clk);
    {rx_start, frame_end, missing_start, guard_time_bad, missing_end}
      <= 5'h00;
  endtask
  // idle amplitudes flip so stale values never look valid
  task sym(input logic [AMP_W-1:0] f, input logic [AMP_W-1:0] s);
    @(posedge clk);
    sym_valid <= 1'b1;
    sym_first_amp <= f;
    sym_second_amp <= s;
    @(posedge clk);
    sym_valid <= 1'b0;
    sym_first_amp <= ~f;
    sym_second_amp <= ~s;
  endtask
  task psk(input logic b, input logic [AMP_W-1:0] st);
    @(posedge clk);
    psk_bit_valid <= 1'b1;
    psk_bit <= b;
    psk_strength <= st;
    @(posedge clk);
    psk_bit_valid <= 1'b0;
    psk_bit <= ~b;
    psk_strength <= ~st;
  endtask
  task burst(input logic b);
    @(posedge clk);
    burst_phase <= b;
  endtask
endmodule // card_model
`default_nettype wire

/* File: test/testbench.sv */
`include "rx_decoder_cfg.svh"
`timescale 1ns/100ps
`default_nettype none
module testbench;
  localparam int AMP_W = 4;
  logic             clk = 1'b0;
  logic             rst = 1'b1;
  logic             hsel, hwrite, hready, hreadyout, hresp, irq;
  logic [7:0]       haddr, tx_rx_phase_offset;
  logic [1:0]       htrans, protocol_select, pll_time_constant;
  logic [2:0]       hsize;
  logic [31:0]      hwdata, hrdata;
  logic [3:0]       pulses_per_bit;
  logic [5:0]       gain_db;
  logic             low_pass_off, framing_type_a, filter_amp_det;
  logic             receiver_on, rx_bit, rx_bit_valid, bit_collision;
  logic             framing_error, rx_start, frame_end, burst_phase;
  logic             sym_valid, psk_bit_valid, psk_bit, missing_start;
  logic             guard_time_bad, missing_end;
  logic [AMP_W-1:0] sym_first_amp, sym_second_amp, psk_strength;
  int               error_cnt = 0;
  int               num_checks = 0;
  assign hready = hreadyout;
  always #5 clk = ~clk;
  rx_decoder_regs #(.AMP_W(AMP_W)) i_rx_decoder_regs (.clk, .rst, .hsel,
    .haddr, .htrans, .hwrite, .hsize, .hwdata, .hready, .hrdata, .hreadyout,
    .hresp, .rx_start, .frame_end, .burst_phase, .sym_valid, .sym_first_amp,
    .sym_second_amp, .psk_bit_valid, .psk_bit, .psk_strength, .missing_start,
    .guard_time_bad, .missing_end, .pulses_per_bit, .protocol_select,
    .gain_db, .low_pass_off, .framing_type_a, .tx_rx_phase_offset,
    .filter_amp_det, .pll_time_constant, .receiver_on, .rx_bit,
    .rx_bit_valid, .bit_collision, .framing_error, .irq);
  card_model #(.AMP_W(AMP_W)) i_card_model (.clk, .rx_start, .frame_end,
    .burst_phase, .sym_valid, .sym_first_amp, .sym_second_amp,
    .psk_bit_valid, .psk_bit, .psk_strength, .missing_start,
    .guard_time_bad, .missing_end);
  // ====================================================
  // bus and compare helpers
  task final_report;
    $display("checks %0d mismatches %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  task chk(input logic [7:0] got, input logic [7:0] exp, input string m);
    num_checks++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("wrong value at %0t: %s got %h exp %h", $time, m, got, exp);
    end
  endtask
  task wait_rdy;
    int n;
    n = 0;
    do @(posedge clk); while (hready !== 1'b1 && ++n < 20);
    if (hready !== 1'b1)
    begin
      error_cnt++;
      final_report();
    end
  endtask
  task bus(input logic w, input logic [5:0] idx, input logic [7:0] wd,
           output logic [7:0] rd);
    @(posedge clk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= {idx, 2'h0};
    hwrite <= w;
    hsize <= 3'h2;
    wait_rdy();
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= {24'h000000, wd};
    wait_rdy();
    rd = hrdata[7:0];
  endtask
  task wr(input logic [5:0] idx, input logic [7:0] v);
    logic [7:0] d;
    bus(1'b1, idx, v, d);
  endtask
  task rchk(input logic [5:0] idx, input logic [7:0] exp);
    logic [7:0] d;
    bus(1'b0, idx, 8'h00, d);
    chk(d, exp, "register read");
  endtask
  task setup(input logic [7:0] f);
    logic [7:0] d;
    bus(1'b0, `IDX_DECODER_SETUP, 8'h00, d);
    wr(`IDX_DECODER_SETUP, (d & 8'h86) | f);
  endtask
  task settle;
    repeat (2) @(posedge clk);
    #1;
  endtask
  // ====================================================
  // scenarios
  task t_reset;
    rchk(`IDX_RX_CTL_ONE, `RST_RX_CTL_ONE);
    rchk(`IDX_DECODER_SETUP, `RST_DECODER_SETUP);
    rchk(`IDX_TX_RX_PHASE, `RST_TX_RX_PHASE);
    rchk(`IDX_THRESHOLDS, `RST_THRESHOLDS);
    rchk(`IDX_PSK_DEMOD, `RST_PSK_DEMOD);
    rchk(`IDX_IRQ_STATUS, 8'h00);
    rchk(`IDX_DECODER_STATE, 8'h00);
    wr(6'h10, 8'h5A);
    rchk(6'h10, 8'h00);
    chk(pulses_per_bit, 8'h08, "pulses");
    chk(gain_db, 8'h23, "gain");
    chk(framing_type_a, 8'h01, "framing");
    chk(pll_time_constant, 8'h03, "pll");
    chk(filter_amp_det, 8'h01, "filter");
    $display("reset test done");
  endtask
  task t_config;
    logic [7:0] gains [4];
    logic [2:0] c;
    gains = '{8'h14, 8'h18, 8'h1F, 8'h23};
    for (int k = 0; k < 4; k++)
    begin
      c = k[2:0];
      wr(`IDX_RX_CTL_ONE, {c, 2'h2, 1'b1, c[1:0]});
      settle();
      chk(pulses_per_bit, 8'h01 << k, "pulses");
      chk(gain_db, gains[k], "gain");
      chk(protocol_select, 8'h02, "protocol");
      chk(low_pass_off, 8'h01, "low pass");
    end
    wr(`IDX_RX_CTL_ONE, 8'hB3);
    rchk(`IDX_IRQ_STATUS, 8'h08);
    chk(irq, 8'h00, "masked irq");
    wr(`IDX_IRQ_STATUS, 8'h08);
    rchk(`IDX_IRQ_STATUS, 8'h00);
    wr(`IDX_RX_CTL_ONE, `RST_RX_CTL_ONE);
    wr(`IDX_TX_RX_PHASE, 8'h5A);
    settle();
    chk(tx_rx_phase_offset, 8'h5A, "phase");
    setup(8'h00);
    settle();
    chk(framing_type_a, 8'h00, "framing");
    setup(8'h08);
    $display("config test done");
  endtask
  task t_frame;
    wr(`IDX_IRQ_MASK, 8'h01);
    i_card_model.ev(0);
    i_card_model.sym(4'hF, 4'h0);
    #1;
    chk({rx_bit_valid, rx_bit}, 8'h03, "bit one");
    i_card_model.ev(1);
    #1;
    chk(receiver_on, 8'h00, "single frame");
    settle();
    chk(irq, 8'h01, "frame irq");
    wr(`IDX_IRQ_STATUS, 8'h01);
    settle();
    chk(irq, 8'h00, "irq cleared");
    setup(8'h48);
    i_card_model.ev(0);
    i_card_model.ev(1);
    #1;
    chk(receiver_on, 8'h01, "multi frame");
    rchk(`IDX_DECODER_STATE, 8'h01);
    $display("frame test done");
  endtask
  task t_coll;
    wr(`IDX_THRESHOLDS, 8'h8F);
    setup(8'h68);
    i_card_model.sym(4'h7, 4'h0);
    #1;
    chk(rx_bit_valid, 8'h00, "weak symbol");
    i_card_model.sym(4'hF, 4'hF);
    #1;
    chk(bit_collision, 8'h01, "collision");
    i_card_model.sym(4'hF, 4'h0);
    #1;
    chk({rx_bit_valid, rx_bit}, 8'h02, "masked bit");
    i_card_model.ev(1);
    setup(8'h48);
    i_card_model.sym(4'hF, 4'hE);
    #1;
    chk({bit_collision, rx_bit}, 8'h01, "below level");
    $display("collision test done");
  endtask
  task t_framing;
    for (int k = 0; k < 3; k++)
    begin
      i_card_model.ev(2 + k);
      #1;
      chk(framing_error, 8'h01, "fault flagged");
      wr(`IDX_PSK_DEMOD, 8'h1E | (8'h80 >> k));
      i_card_model.ev(2 + k);
      #1;
      chk(framing_error, 8'h00, "fault ignored");
      wr(`IDX_PSK_DEMOD, `RST_PSK_DEMOD);
    end
    $display("framing test done");
  endtask
  task t_psk;
    setup(8'h49);
    i_card_model.psk(1'b0, 4'h8);
    #1;
    chk({rx_bit_valid, rx_bit}, 8'h02, "psk zero");
    i_card_model.psk(1'b1, 4'h7);
    #1;
    chk(rx_bit_valid, 8'h00, "weak psk");
    i_card_model.sym(4'hF, 4'h0);
    #1;
    chk(rx_bit_valid, 8'h00, "symbol ignored");
    i_card_model.burst(1'b1);
    settle();
    chk(pll_time_constant, 8'h02, "burst pll");
    i_card_model.burst(1'b0);
    $display("psk test done");
  endtask
  initial
  begin
    #500000;
    error_cnt++;
    final_report();
  end
  initial
  begin
    {hsel, hwrite, htrans, hsize, haddr, hwdata} = '0;
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    t_reset();
    t_config();
    t_frame();
    t_coll();
    t_framing();
    t_psk();
    final_report();
  end
endmodule // testbench
`default_nettype wire
